// file: common/mcs_regs.vh
// Constants for the motion command sequencer: command word layout,
// axis count and timing figures.
// Assumes it is included by bare name from every design file.
//
// What this block does
// - Each axis reports whether its command pre-register has room.
// - A write to a full pre-register replaces the second stage.
// - Continuous-sequence flag: 1 marks sequence started, 0 finished.
// - Dwell holds the axis for given milliseconds with no motion.
// - Group start acts on all armed idle axes together, group stop on the axes that group start launched.
// - Start and stop lines of several cards are wired together.
// - Group start launches each axis with its prepared profile.
// - Moves carry distance, velocities and acceleration times.
// - S-curve moves carry separate accel and decel intervals.
`ifndef MCS_REGS_VH
`define MCS_REGS_VH

// ==========================================================
// Geometry
`define MCS_AXES 2
`define MCS_CMD_W 163

// ==========================================================
// Command word fields (LSB positions)
`define MCS_F_DWELL 0
`define MCS_F_SCURVE 1
`define MCS_F_ABS 2
`define MCS_F_DIST_LSB 3
`define MCS_F_PAUSE_LSB 3
`define MCS_F_SVEL_LSB 35
`define MCS_F_PVEL_LSB 59
`define MCS_F_TACC_LSB 83
`define MCS_F_TDEC_LSB 99
`define MCS_F_SVACC_LSB 115
`define MCS_F_SVDEC_LSB 139

// ==========================================================
// Reset values
`define MCS_STAGE_RST 1'b0
`define MCS_PULSE_RST 1'b0

// ==========================================================
// Timing
`define MCS_CLK_PERIOD_NS 10
`define MCS_MS_IN_NS 1000000
`define MCS_MS_CYCLES (`MCS_MS_IN_NS / `MCS_CLK_PERIOD_NS)

`endif

// file: core/mcs_prereg.v
// Two-stage command pre-register for one axis.
// Assumes push and pop are single-cycle strobes in the sys_clk domain.
`timescale 1ns/1ns
`include "mcs_regs.vh"

module mcs_prereg
(
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    input wire ce,
    // Filling side
    input wire push,
    input wire [`MCS_CMD_W-1:0] word,
    // Draining side
    input wire pop,
    output reg headValid,
    output reg [`MCS_CMD_W-1:0] headWord,
    // Status
    output reg roomFree
);

    reg tailValid;
    reg [`MCS_CMD_W-1:0] tailWord;
    reg next_headValid;
    reg next_tailValid;

    // ==========================================================
    // Occupancy; pop and push may land in one cycle
    always @*
    begin
        next_headValid = headValid;
        next_tailValid = tailValid;
        if (pop)
        begin
            next_headValid = tailValid | push;
            next_tailValid = tailValid & push;
        end
        else if (push)
        begin
            next_headValid = 1'b1;
            next_tailValid = headValid;
        end
    end

    // ==========================================================
    // Stage registers; a full queue keeps the head and loses
    // the old tail, since the host was told there was no room
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            headValid <= `MCS_STAGE_RST;
            tailValid <= `MCS_STAGE_RST;
            headWord <= {`MCS_CMD_W{1'b0}};
            tailWord <= {`MCS_CMD_W{1'b0}};
            roomFree <= 1'b1;
        end
        else if (ce)
        begin
            headValid <= next_headValid;
            tailValid <= next_tailValid;
            roomFree <= ~next_tailValid;
            if (pop)
                headWord <= tailValid ? tailWord : word;
            else if (push && !headValid)
                headWord <= word;
            if (push && (headValid || tailValid) && !(pop && !tailValid))
                tailWord <= word;
        end
    end

endmodule

// file: core/mcs_sequencer.v
// Per-axis motion command sequencer with dwell and group start/stop.
// Assumes a profile generator behind moveStart/moveCmd that answers
// with moveDone, and sync lines wired across cards outside the chip.
`timescale 1ns/1ns
`include "mcs_regs.vh"

module mcs_sequencer
#(
    parameter integer MS_CYCLES = `MCS_MS_CYCLES
)
(
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    input wire ce,
    // Host command port
    input wire cmdWrite,
    input wire groupLoad,
    input wire cmdAxis,
    input wire [`MCS_CMD_W-1:0] cmdWord,
    input wire [`MCS_AXES-1:0] contFlag,
    // Host group control
    input wire groupStart,
    input wire groupStop,
    input wire [`MCS_AXES-1:0] groupAxisList,
    input wire [1:0] groupAxisCount,
    input wire groupLeadAxis,
    // Card-to-card sync lines
    input wire syncStartIn,
    input wire syncStopIn,
    output reg syncStartOut,
    output reg syncStopOut,
    // Profile generator side
    input wire [`MCS_AXES-1:0] moveDone,
    output wire [`MCS_AXES-1:0] moveStart,
    output wire [`MCS_AXES*`MCS_CMD_W-1:0] moveCmd,
    output wire [`MCS_AXES-1:0] axisHalt,
    // Status
    output wire [`MCS_AXES-1:0] preregEmpty,
    output wire [`MCS_AXES-1:0] axisBusy,
    output wire [`MCS_AXES-1:0] seqActive
);

    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_MOVE = 3'h2;
    localparam [2:0] ST_DWELL = 3'h4;
    localparam [31:0] TICK_FULL = MS_CYCLES - 1;
    localparam [16:0] TICK_LAST = TICK_FULL[16:0];

    // ==========================================================
    // Decoding helpers
    function isDwell;
        input [`MCS_CMD_W-1:0] w;
        begin
            isDwell = w[`MCS_F_DWELL];
        end
    endfunction

    function [1:0] setCount;
        input [`MCS_AXES-1:0] list;
        begin
            setCount = {1'b0, list[0]} + {1'b0, list[1]};
        end
    endfunction

    function lowestAxis;
        input [`MCS_AXES-1:0] list;
        begin
            lowestAxis = ~list[0];
        end
    endfunction

    // ==========================================================
    // Group request check: lead must be first listed axis
    wire leadOk;
    assign leadOk = groupAxisList[groupLeadAxis]
                  & (lowestAxis(groupAxisList) == groupLeadAxis)
                  & (setCount(groupAxisList) == groupAxisCount);

    // ==========================================================
    // Sync line drive; every card, this one included, acts only
    // on the wired line so all axes move on the same edge
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            syncStartOut <= `MCS_PULSE_RST;
            syncStopOut <= `MCS_PULSE_RST;
        end
        else if (ce)
        begin
            syncStartOut <= groupStart & leadOk;
            syncStopOut <= groupStop & leadOk;
        end
    end

    // ==========================================================
    // Per-axis execution
    genvar a;
    generate
        for (a = 0; a < `MCS_AXES; a = a + 1)
        begin : axis
            localparam [0:0] AXIS_ID = (a == 1) ? 1'b1 : 1'b0;
            wire sel;
            wire headValid;
            wire [`MCS_CMD_W-1:0] headWord;
            wire goGroup;
            wire stopHit;
            wire dwellEnd;
            reg [2:0] state;
            reg [2:0] next_state;
            reg takeHead;
            reg popHead;
            reg launch;
            reg [`MCS_CMD_W-1:0] launchWord;
            reg [15:0] dwellLeft;
            reg [16:0] tickCnt;
            reg armed;
            reg [`MCS_CMD_W-1:0] armWord;
            reg inGroup;
            reg startPulse;
            reg haltPulse;
            reg [`MCS_CMD_W-1:0] cmdOut;
            reg busy;
            reg seqFlag;

            assign sel = (cmdAxis == AXIS_ID);
            assign goGroup = syncStartIn & armed;
            assign stopHit = syncStopIn & inGroup;
            assign dwellEnd = (dwellLeft == 16'h0);

            // Dwells and moves share one queue, so order holds
            mcs_prereg u_prereg
            (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .ce(ce),
                .push(cmdWrite & sel),
                .word(cmdWord),
                .pop(popHead),
                .headValid(headValid),
                .headWord(headWord),
                .roomFree(preregEmpty[a])
            );

            // Next-state logic; the flag lets a queued command follow
            // the finished one on the same edge, with no idle gap
            always @*
            begin
                next_state = state;
                takeHead = 1'b0;
                popHead = 1'b0;
                launch = 1'b0;
                launchWord = headWord;
                case (state)
                    ST_IDLE:
                    begin
                        if (goGroup)
                        begin
                            launch = 1'b1;
                            launchWord = armWord;
                            next_state = ST_MOVE;
                        end
                        else
                            takeHead = headValid;
                    end
                    ST_MOVE:
                    begin
                        if (moveDone[a])
                        begin
                            next_state = ST_IDLE;
                            takeHead = headValid & contFlag[a];
                        end
                    end
                    ST_DWELL:
                    begin
                        if (dwellEnd)
                        begin
                            next_state = ST_IDLE;
                            takeHead = headValid & contFlag[a];
                        end
                    end
                    default:
                        next_state = ST_IDLE;
                endcase
                if (takeHead)
                begin
                    popHead = 1'b1;
                    if (isDwell(headWord))
                        next_state = ST_DWELL;
                    else
                    begin
                        launch = 1'b1;
                        next_state = ST_MOVE;
                    end
                end
            end

            // State, dwell timer and group arming
            always @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    state <= ST_IDLE;
                    dwellLeft <= 16'h0;
                    tickCnt <= 17'h0;
                    armed <= 1'b0;
                    armWord <= {`MCS_CMD_W{1'b0}};
                    inGroup <= 1'b0;
                end
                else if (ce)
                begin
                    state <= next_state;
                    if (takeHead && isDwell(headWord))
                    begin
                        dwellLeft <= headWord[`MCS_F_PAUSE_LSB +: 16];
                        tickCnt <= 17'h0;
                    end
                    else if (state == ST_DWELL && !dwellEnd)
                    begin
                        if (tickCnt == TICK_LAST)
                        begin
                            tickCnt <= 17'h0;
                            dwellLeft <= dwellLeft - 16'h1;
                        end
                        else
                            tickCnt <= tickCnt + 17'h1;
                    end
                    // A fresh load beats the clear of the start edge
                    if (groupLoad && sel)
                    begin
                        armed <= 1'b1;
                        armWord <= cmdWord;
                    end
                    else if (goGroup && state == ST_IDLE)
                        armed <= 1'b0;
                    if (goGroup && state == ST_IDLE)
                        inGroup <= 1'b1;
                    else if (next_state != ST_MOVE || launch)
                        inGroup <= 1'b0;
                end
            end

            // Launch strobe, command word and status outputs
            always @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    startPulse <= `MCS_PULSE_RST;
                    haltPulse <= `MCS_PULSE_RST;
                    cmdOut <= {`MCS_CMD_W{1'b0}};
                    busy <= 1'b0;
                    seqFlag <= 1'b0;
                end
                else if (ce)
                begin
                    startPulse <= launch;
                    haltPulse <= stopHit & (state == ST_MOVE);
                    if (launch)
                        cmdOut <= launchWord;
                    busy <= (next_state != ST_IDLE);
                    seqFlag <= contFlag[a];
                end
            end

            assign moveStart[a] = startPulse;
            assign axisHalt[a] = haltPulse;
            assign moveCmd[a*`MCS_CMD_W +: `MCS_CMD_W] = cmdOut;
            assign axisBusy[a] = busy;
            assign seqActive[a] = seqFlag;
        end
    endgenerate

endmodule

// file: test/mcs_sequencer_assertions.sv
// Port checker for the motion command sequencer.
// Assumes it is bound onto mcs_sequencer and ce is normally high.
`timescale 1ns/1ns
module mcs_sequencer_chk
#(
    parameter integer MS_CYCLES = 4
)
(
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    input wire ce,
    // Host side
    input wire cmdWrite,
    input wire cmdAxis,
    input wire [1:0] contFlag,
    input wire groupStart,
    input wire groupStop,
    input wire [1:0] groupAxisList,
    input wire [1:0] groupAxisCount,
    input wire groupLeadAxis,
    // Sync lines
    input wire syncStopIn,
    input wire syncStartOut,
    input wire syncStopOut,
    // Profile side and status
    input wire [1:0] moveDone,
    input wire [1:0] moveStart,
    input wire [325:0] moveCmd,
    input wire [1:0] axisHalt,
    input wire [1:0] preregEmpty,
    input wire [1:0] axisBusy,
    input wire [1:0] seqActive
);
// ==========================================================
// Group request counts only through the lowest listed axis
wire leadOk = groupAxisList[groupLeadAxis] && (!groupLeadAxis || !groupAxisList[0])
    && ({1'b0, groupAxisList[0]} + {1'b0, groupAxisList[1]} == groupAxisCount);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!nrst || !ce);
// A move launched and not yet answered by the drive
sequence s_run0;
    moveStart[0] ##1 (!moveDone[0])[*3];
endsequence
property p_startOut; groupStart && leadOk |=> syncStartOut; endproperty
property p_stopOut; groupStop && leadOk |=> syncStopOut; endproperty
property p_noDwell0; moveStart[0] |-> !moveCmd[0]; endproperty
property p_noDwell1; moveStart[1] |-> !moveCmd[163]; endproperty
property p_emptyFell; $fell(preregEmpty[0]) |-> $past(cmdWrite && !cmdAxis); endproperty
property p_seq; $past(nrst && ce) |-> seqActive == $past(contFlag); endproperty
property p_halt; |axisHalt |-> $past(syncStopIn); endproperty
property p_busy; s_run0 |-> axisBusy[0]; endproperty
a_startOut: assert property (p_startOut) else $error("group start not sent");
a_stopOut: assert property (p_stopOut) else $error("group stop not sent");
a_noDwell0: assert property (p_noDwell0) else $error("dwell moved axis 0");
a_noDwell1: assert property (p_noDwell1) else $error("dwell moved axis 1");
a_emptyFell: assert property (p_emptyFell) else $error("empty fell w/o write");
a_seq: assert property (p_seq) else $error("sequence flag not followed");
a_halt: assert property (p_halt) else $error("halt without stop line");
a_busy: assert property (p_busy) else $error("axis idle while moving");
endmodule
bind mcs_sequencer mcs_sequencer_chk #(.MS_CYCLES(MS_CYCLES)) chk (.*);

// file: test/mcs_profile_model.sv
// Drive-side stand-in: ends each launched move after a set delay.
// Assumes one-cycle moveStart pulses; delay of at least 1.
`timescale 1ns/1ns
module mcs_profile_model
(
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    // Sequencer side
    input wire [1:0] moveStart,
    input wire [1:0] axisHalt,
    input wire [7:0] delay,
    output reg [1:0] moveDone
);
// ==========================================================
// Countdown per axis; a halt cuts the move short like a real drive
reg [7:0] left [0:1];
integer a;
always @(posedge sys_clk or negedge nrst)
begin
    for (a = 0; a < 2; a = a + 1)
    begin
        moveDone[a] <= 1'b0;
        if (!nrst)
            left[a] <= 8'h00;
        else if (moveStart[a])
            left[a] <= delay;
        else if (left[a] == 8'h01 || (axisHalt[a] && left[a] != 8'h00))
        begin
            left[a] <= 8'h00;
            moveDone[a] <= 1'b1;
        end
        else if (left[a] != 8'h00)
            left[a] <= left[a] - 8'h01;
    end
end
endmodule

// file: test/mcs_sequencer_test.sv
// Self-checking bench for the motion command sequencer.
// Assumes MS_CYCLES of 4 and sync outputs looped back to sync inputs.
`timescale 1ns/1ns
module mcs_sequencer_test;
reg sys_clk = 1'b0;
reg nrst = 1'b0;
reg ce = 1'b1;
reg cmdWrite = 1'b0;
reg groupLoad = 1'b0;
reg cmdAxis = 1'b0;
reg [162:0] cmdWord = 163'h0;
reg [1:0] contFlag = 2'h0;
reg groupStart = 1'b0;
reg groupStop = 1'b0;
reg [1:0] groupAxisList = 2'h0;
reg [1:0] groupAxisCount = 2'h0;
reg groupLeadAxis = 1'b0;
reg [7:0] delay = 8'h01;
wire syncStartOut;
wire syncStopOut;
wire [1:0] moveDone, moveStart, axisHalt, preregEmpty, axisBusy, seqActive;
wire [325:0] moveCmd;
integer error_cnt = 0;
integer tests_run = 0;
integer cyc = 0;
integer k;
integer nSync = 0;
integer nStart [0:1];
integer tStart [0:1];
reg [162:0] lastCmd [0:1];
// ==========================================================
// Block under test, sync lines wired as across cards
mcs_sequencer #(.MS_CYCLES(4)) uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .cmdWrite(cmdWrite), .groupLoad(groupLoad), .cmdAxis(cmdAxis), .cmdWord(cmdWord),
    .contFlag(contFlag), .groupStart(groupStart), .groupStop(groupStop),
    .groupAxisList(groupAxisList), .groupAxisCount(groupAxisCount),
    .groupLeadAxis(groupLeadAxis), .syncStartIn(syncStartOut), .syncStopIn(syncStopOut),
    .syncStartOut(syncStartOut), .syncStopOut(syncStopOut), .moveDone(moveDone),
    .moveStart(moveStart), .moveCmd(moveCmd), .axisHalt(axisHalt),
    .preregEmpty(preregEmpty), .axisBusy(axisBusy), .seqActive(seqActive));
mcs_profile_model pm (.sys_clk(sys_clk), .nrst(nrst), .moveStart(moveStart),
    .axisHalt(axisHalt), .delay(delay), .moveDone(moveDone));
always #5 sys_clk = ~sys_clk;
// Launch log and hang guard, sampled between edges
always @(negedge sys_clk)
begin
    cyc = cyc + 1;
    nSync = nSync + syncStartOut;
    for (k = 0; k < 2; k = k + 1)
        if (moveStart[k] === 1'b1)
        begin
            nStart[k] = nStart[k] + 1;
            tStart[k] = cyc;
            lastCmd[k] = moveCmd[k*163 +: 163];
        end
    if (cyc == 5000)
    begin
        error_cnt = error_cnt + 1;
        close_out;
    end
end
// ==========================================================
// Helpers
function [162:0] mv(input [31:0] d, input [2:0] f);
    mv = {24'h00000a, 24'h00000b, 16'h0010, 16'h0011, 24'h001000, 24'h000100, d, f};
endfunction
function [162:0] dw(input [15:0] ms);
    dw = {144'h0, ms, 3'b001};
endfunction
task chk(input string what, input [162:0] exp, input [162:0] got);
begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
end
endtask
// Queue write (kind 0) or group arm (kind 1), one-cycle strobe
task put(input integer kind, input a, input [162:0] w);
begin
    @(negedge sys_clk);
    cmdAxis = a;
    cmdWord = w;
    cmdWrite = (kind == 0);
    groupLoad = (kind != 0);
    @(negedge sys_clk);
    cmdWrite = 1'b0;
    groupLoad = 1'b0;
end
endtask
task grp(input st, input [1:0] l, input [1:0] n, input ld);
begin
    @(negedge sys_clk);
    groupAxisList = l;
    groupAxisCount = n;
    groupLeadAxis = ld;
    groupStart = st;
    groupStop = !st;
    @(negedge sys_clk);
    groupStart = 1'b0;
    groupStop = 1'b0;
end
endtask
// ==========================================================
// Scenarios
task t_single;
begin
    put(0, 1'b1, mv(32'h00004e20, 3'b100));
    chk("early", 0, moveStart[1]);
    @(negedge sys_clk);
    chk("start", 1, moveStart[1]);
    chk("cmd", mv(32'h00004e20, 3'b100), moveCmd[325:163]);
    chk("busy", 1, axisBusy[1]);
    repeat (6) @(negedge sys_clk);
    chk("idle", 0, axisBusy[1]);
end
endtask
// Dwell of 2 ms at 4 cycles per ms holds the axis 9 cycles, no launch
task t_dwell;
    integer n, s;
begin
    s = nStart[0];
    n = 0;
    put(0, 1'b0, dw(16'h0002));
    repeat (30)
    begin
        @(negedge sys_clk);
        n = n + axisBusy[0];
    end
    chk("dwellLen", 9, n);
    chk("dwellMoves", s, nStart[0]);
end
endtask
// Clock enable low: a queued write and a flag change are both ignored
task t_hold;
    integer s;
begin
    s = nStart[0];
    ce = 1'b0;
    contFlag = 2'b10;
    put(0, 1'b0, mv(32'h7, 3'b000));
    repeat (2) @(negedge sys_clk);
    chk("holdSeq", 2'b00, seqActive);
    chk("holdRoom", 2'b11, preregEmpty);
    contFlag = 2'b00;
    ce = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("holdMoves", s, nStart[0]);
end
endtask
// Full queue behind a slow move: last write replaces stage 2
task t_queue;
    integer s;
begin
    delay = 8'h0c;
    contFlag = 2'b01;
    s = nStart[0];
    put(0, 1'b0, mv(32'h1, 3'b000));
    repeat (3) @(negedge sys_clk);
    chk("seqOn", 2'b01, seqActive);
    chk("roomA", 1, preregEmpty[0]);
    put(0, 1'b0, dw(16'h0000));
    put(0, 1'b0, mv(32'h2, 3'b000));
    chk("full", 0, preregEmpty[0]);
    put(0, 1'b0, mv(32'h3, 3'b001 ^ 3'b101));
    repeat (40) @(negedge sys_clk);
    chk("launches", s + 2, nStart[0]);
    chk("lastCmd", mv(32'h3, 3'b100), lastCmd[0]);
    chk("drained", 1, preregEmpty[0]);
    contFlag = 2'b00;
    repeat (2) @(negedge sys_clk);
    chk("seqOff", 2'b00, seqActive);
end
endtask
task t_group;
    integer s;
    reg [1:0] h;
begin
    delay = 8'h14;
    h = 2'b00;
    put(1, 1'b0, mv(32'h5, 3'b010));
    put(1, 1'b1, mv(32'h6, 3'b110));
    s = nSync;
    grp(1'b1, 2'b11, 2'b10, 1'b1);
    repeat (4) @(negedge sys_clk);
    chk("badLead", s, nSync);
    grp(1'b1, 2'b11, 2'b10, 1'b0);
    repeat (4) @(negedge sys_clk);
    chk("together", tStart[0], tStart[1]);
    chk("cmd0", mv(32'h5, 3'b010), moveCmd[162:0]);
    chk("cmd1", mv(32'h6, 3'b110), moveCmd[325:163]);
    grp(1'b0, 2'b11, 2'b10, 1'b0);
    repeat (4)
    begin
        @(negedge sys_clk);
        if (h == 2'b00)
            h = axisHalt;
    end
    chk("halt", 2'b11, h);
    repeat (6) @(negedge sys_clk);
    chk("stopped", 2'b00, axisBusy);
end
endtask
task close_out;
begin
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
end
endtask
// ==========================================================
// Main sequence
initial
begin
    for (k = 0; k < 2; k = k + 1)
    begin
        nStart[k] = 0;
        tStart[k] = 0;
    end
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    chk("rstEmpty", 2'b11, preregEmpty);
    chk("rstBusy", 2'b00, axisBusy);
    t_single;
    t_dwell;
    t_hold;
    t_queue;
    t_group;
    close_out;
end
endmodule
